// ### alcrb_pkg.sv
// Purpose: shared constants, types and helpers of the cpu register bridge
// Assumes: 32-bit bus data, 16-bit bus byte address, 14-bit register word address
// Notes: offsets below are byte offsets; the word address is the byte offset over four
package alcrb_pkg;

  localparam int AXI_ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int WADDR_W = 14;

  localparam logic [1:0] RESP_OKAY = 2'h0;

  // filesystem register file areas
  localparam logic [15:0] FS_PARAM_AREA_END = 16'h00FF;
  localparam logic [15:0] FS_STATUS_AREA_BASE = 16'h0100;
  localparam logic [15:0] FS_AREA_END = 16'h0FFF;

  localparam logic [15:0] OFF_FILE_NAME_INDEX = 16'h0000;
  localparam logic [15:0] OFF_FILE_LENGTH = 16'h0004;
  localparam logic [15:0] OFF_FILE_SIZE_REG = 16'h0008;
  localparam logic [15:0] OFF_FILE_TIMESTAMP = 16'h000C;
  localparam logic [15:0] OFF_FILESYSTEM_COMMAND = 16'h0010;
  localparam logic [15:0] OFF_FILESYSTEM_STATUS = 16'h0100;

  localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam int FS_READ_LATENCY = 2;

  typedef enum logic [1:0] {
    ALCRB_IDLE = 2'b00,
    ALCRB_READ = 2'b01
  } alcrb_state_t;

  typedef struct packed {
    logic [WADDR_W-1:0] addr;
    logic [DATA_W-1:0] value;
    logic [LANE_W-1:0] lanes;
  } alcrb_wr_t;

  function automatic logic [15:0] word_to_byte(input logic [WADDR_W-1:0] addr);
    word_to_byte = {addr, 2'b00};
  endfunction

  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [LANE_W-1:0] lanes);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < LANE_W; i++)
    begin
      if (lanes[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_lanes = res;
  endfunction

  function automatic logic in_fs_area(input logic [WADDR_W-1:0] addr);
    in_fs_area = (word_to_byte(addr) <= FS_AREA_END);
  endfunction

endpackage

// ### alcrb_fs_regs.sv
// Purpose: filesystem parameter and status register file on the user clock
// Assumes: register interface from the bridge, same clock, word address held during reads
// Notes: parameter area is write-only, status area read-only; reads answer two cycles later
`timescale 1ns/1ps
`default_nettype none
module alcrb_fs_regs (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr_strobe,
  input wire alcrb_pkg::alcrb_wr_t i_wr,
  input wire logic i_rd_req,
  input wire logic i_filesystem_busy,
  input wire logic i_filesystem_error,
  output logic [26:0] o_file_name_input,
  output logic [26:0] o_file_length_input,
  output logic [2:0] o_file_size_select,
  output logic [31:0] o_file_timestamp,
  output logic [1:0] o_filesystem_command_code,
  output logic o_command_start_pulse,
  output logic [31:0] o_rd_value,
  output logic o_rd_valid
);

  logic [15:0] boff;
  logic param_area;
  logic status_area;
  logic rd_d1;
  logic [31:0] cur_param;
  logic [31:0] merged;

  assign boff = alcrb_pkg::word_to_byte(i_wr.addr);

  // current word of the addressed parameter, merged lane by lane
  always_comb
  begin
    unique case (boff)
      alcrb_pkg::OFF_FILE_NAME_INDEX: cur_param = {5'h00, o_file_name_input};
      alcrb_pkg::OFF_FILE_LENGTH: cur_param = {5'h00, o_file_length_input};
      alcrb_pkg::OFF_FILE_SIZE_REG: cur_param = {29'h0, o_file_size_select};
      alcrb_pkg::OFF_FILE_TIMESTAMP: cur_param = o_file_timestamp;
      alcrb_pkg::OFF_FILESYSTEM_COMMAND: cur_param = {30'h0, o_filesystem_command_code};
      default: cur_param = alcrb_pkg::READ_ZERO;
    endcase
  end

  assign merged = alcrb_pkg::merge_lanes(cur_param, i_wr.value, i_wr.lanes); // see RULE9
  // area picked from the upper word address bits
  assign param_area = (i_wr.addr[13:6] == 8'h00); // see RULE15 see RULE13
  assign status_area = (i_wr.addr[13:10] == 4'h0) && !param_area; // see RULE15 see RULE14

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_file_name_input <= alcrb_pkg::PARAM_RESET[26:0];
      o_file_length_input <= alcrb_pkg::PARAM_RESET[26:0];
      o_file_size_select <= alcrb_pkg::PARAM_RESET[2:0];
      o_file_timestamp <= alcrb_pkg::PARAM_RESET;
      o_filesystem_command_code <= alcrb_pkg::PARAM_RESET[1:0];
    end
    else if (i_ce && i_wr_strobe && param_area)
    begin
      unique case (boff)
        alcrb_pkg::OFF_FILE_NAME_INDEX: o_file_name_input <= merged[26:0]; // see RULE17
        alcrb_pkg::OFF_FILE_LENGTH: o_file_length_input <= merged[26:0]; // see RULE18
        alcrb_pkg::OFF_FILE_SIZE_REG: o_file_size_select <= merged[2:0]; // see RULE19
        alcrb_pkg::OFF_FILE_TIMESTAMP: o_file_timestamp <= merged; // see RULE20
        alcrb_pkg::OFF_FILESYSTEM_COMMAND: o_filesystem_command_code <= merged[1:0]; // see RULE21
        default:
        begin
        end
      endcase
    end
  end

  // any write to the command register launches a command
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_command_start_pulse <= 1'b0;
    end
    else if (i_ce)
    begin
      o_command_start_pulse <= i_wr_strobe && (boff == alcrb_pkg::OFF_FILESYSTEM_COMMAND); // see RULE21
    end
  end

  // two-flop delay of the read request makes read valid
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_d1 <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_value <= alcrb_pkg::READ_ZERO;
    end
    else if (i_ce)
    begin
      rd_d1 <= i_rd_req; // see RULE16
      o_rd_valid <= rd_d1; // see RULE16
      if (rd_d1)
      begin
        if (status_area && boff == alcrb_pkg::OFF_FILESYSTEM_STATUS)
        begin
          o_rd_value <= {30'h00000000, i_filesystem_error, i_filesystem_busy}; // see RULE22 see RULE23
        end
        else
        begin
          o_rd_value <= alcrb_pkg::READ_ZERO;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### alcrb_bridge.sv
// Purpose: AXI4-Lite slave on the cpu clock bridged to a register interface on the user clock
// Assumes: i_clk_user unrelated to i_clk_sys; offload register file answers every read request
// Notes: one write and one read in flight at a time; toggle handshakes cross the clocks
//
// Overview of operation
// RULE1: 32-bit AXI4-Lite slave on cpu clock, accesses replayed in the user clock domain.
// RULE2: user-side read path chooses offload or filesystem register read data.
// RULE3: write address, write data, read address, read data handled by separate logic.
// RULE4: latched write address and data cross the clocks to form one register write.
// RULE5: read address crosses over; returned read value crosses back to read data channel.
// RULE6: shared word address comes from write address on writes, read address on reads.
// RULE7: register write and register read never issued in the same cycle.
// RULE8: register write is a one-cycle strobe with address, value and byte lanes.
// RULE9: four byte lanes; lane n marks write value bits 8n+7 down to 8n valid.
// RULE10: each slave starts a read on request and returns one word per request.
// RULE11: word address held unchanged during a read until read valid arrives.
// RULE12: slave drives value with read valid; bridge forwards that value to the bus.
// RULE13: filesystem words 0x0000 to 0x00FF are write-only file parameters.
// RULE14: filesystem words 0x0100 to 0x0FFF are read-only status.
// RULE15: filesystem register area chosen from the upper word address bits.
// RULE16: filesystem reads answer two cycles after request through two delay flops.
// RULE17: offset 0x0000 holds the 27-bit file name index.
// RULE18: offset 0x0004 holds the 27-bit file length.
// RULE19: offset 0x0008 holds the 3-bit file size used by format.
// RULE20: offset 0x000C packs seconds, minutes, hours, day, month and year.
// RULE21: offset 0x0010 holds 2-bit command; any write fires a one-shot start.
// RULE22: status at 0x0100 bit 0 is the engine busy flag.
// RULE23: status at 0x0100 bit 1 is the engine error flag.
// RULE24: one OKAY write response per write and one OKAY read beat per read.
// RULE25: new transaction on a channel only after the previous round trip ends.
`timescale 1ns/1ps
`default_nettype none
module alcrb_bridge (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_clk_user,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [15:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [15:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic [13:0] o_reg_word_address,
  output logic o_reg_write_strobe,
  output logic [31:0] o_reg_write_value,
  output logic [3:0] o_reg_write_byte_lanes,
  output logic o_reg_read_request,
  input wire logic [31:0] i_oe_read_value,
  input wire logic i_oe_read_valid,
  output logic [26:0] o_file_name_input,
  output logic [26:0] o_file_length_input,
  output logic [2:0] o_file_size_select,
  output logic [4:0] o_timestamp_seconds,
  output logic [5:0] o_timestamp_minutes,
  output logic [4:0] o_timestamp_hours,
  output logic [4:0] o_timestamp_day,
  output logic [3:0] o_timestamp_month,
  output logic [6:0] o_timestamp_year,
  output logic [1:0] o_filesystem_command_code,
  output logic o_command_start_pulse,
  input wire logic i_filesystem_busy,
  input wire logic i_filesystem_error
);

  // cpu clock side
  logic aw_held;
  logic w_held;
  logic wr_busy;
  logic rd_busy;
  logic [13:0] aw_word;
  logic [31:0] w_value;
  logic [3:0] w_lanes;
  alcrb_pkg::alcrb_wr_t wr_payload;
  logic [13:0] rd_word;
  logic wr_req_tgl;
  logic rd_req_tgl;
  logic wack_s1;
  logic wack_s2;
  logic wack_s3;
  logic rack_s1;
  logic rack_s2;
  logic rack_s3;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_launch;
  logic b_done;
  logic r_done;
  logic next_aw_held;
  logic next_w_held;
  logic next_wr_busy;
  logic next_rd_busy;

  // user clock side
  logic ce_u1;
  logic ce_u2;
  logic wreq_u1;
  logic wreq_u2;
  logic wreq_u3;
  logic rreq_u1;
  logic rreq_u2;
  logic rreq_u3;
  logic wr_pend;
  logic rd_pend;
  logic wack_tgl;
  logic rack_tgl;
  logic [31:0] rd_value_x;
  alcrb_pkg::alcrb_state_t state;
  logic fs_rd_valid;
  logic [31:0] fs_rd_value;
  logic mux_valid;
  logic [31:0] mux_value;
  logic [31:0] fs_timestamp;
  alcrb_pkg::alcrb_wr_t user_wr;

  assign aw_take = o_awready && i_awvalid; // see RULE3
  assign w_take = o_wready && i_wvalid; // see RULE3
  assign ar_take = o_arready && i_arvalid; // see RULE3
  assign wr_launch = aw_held && w_held && !wr_busy;
  assign b_done = o_bvalid && i_bready;
  assign r_done = o_rvalid && i_rready;
  assign next_aw_held = aw_take || (aw_held && !wr_launch);
  assign next_w_held = w_take || (w_held && !wr_launch);
  assign next_wr_busy = wr_launch || (wr_busy && !b_done);
  assign next_rd_busy = ar_take || (rd_busy && !r_done);

  // write address group
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_held <= 1'b0;
      aw_word <= 14'h0000;
      o_awready <= 1'b0;
    end
    else if (i_ce)
    begin
      aw_held <= next_aw_held;
      o_awready <= !next_aw_held && !next_wr_busy; // see RULE25
      if (aw_take)
      begin
        aw_word <= i_awaddr[15:2]; // see RULE4
      end
    end
  end

  // write data group
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      w_held <= 1'b0;
      w_value <= 32'h0000_0000;
      w_lanes <= 4'h0;
      o_wready <= 1'b0;
    end
    else if (i_ce)
    begin
      w_held <= next_w_held;
      o_wready <= !next_w_held && !next_wr_busy; // see RULE25
      if (w_take)
      begin
        w_value <= i_wdata; // see RULE4
        w_lanes <= i_wstrb; // see RULE9
      end
    end
  end

  // launch write across, response once the user side acknowledges
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_busy <= 1'b0;
      wr_req_tgl <= 1'b0;
      wr_payload <= '0;
      wack_s1 <= 1'b0;
      wack_s2 <= 1'b0;
      wack_s3 <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= alcrb_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      wr_busy <= next_wr_busy;
      wack_s1 <= wack_tgl;
      wack_s2 <= wack_s1;
      wack_s3 <= wack_s2;
      o_bresp <= alcrb_pkg::RESP_OKAY; // see RULE24
      if (wr_launch)
      begin
        wr_payload <= '{addr: aw_word, value: w_value, lanes: w_lanes}; // see RULE4
        wr_req_tgl <= !wr_req_tgl; // see RULE1
      end
      if (wack_s2 != wack_s3)
      begin
        o_bvalid <= 1'b1; // see RULE24
      end
      else if (b_done)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // read address group
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_busy <= 1'b0;
      rd_word <= 14'h0000;
      rd_req_tgl <= 1'b0;
      o_arready <= 1'b0;
    end
    else if (i_ce)
    begin
      rd_busy <= next_rd_busy;
      o_arready <= !next_rd_busy; // see RULE25
      if (ar_take)
      begin
        rd_word <= i_araddr[15:2]; // see RULE5
        rd_req_tgl <= !rd_req_tgl;
      end
    end
  end

  // read data group: value is stable in rd_value_x once the ack toggles
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rack_s1 <= 1'b0;
      rack_s2 <= 1'b0;
      rack_s3 <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= alcrb_pkg::READ_ZERO;
      o_rresp <= alcrb_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      rack_s1 <= rack_tgl;
      rack_s2 <= rack_s1;
      rack_s3 <= rack_s2;
      o_rresp <= alcrb_pkg::RESP_OKAY; // see RULE24
      if (rack_s2 != rack_s3)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_value_x; // see RULE5
      end
      else if (r_done)
      begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // user domain: request synchronisers and clock enable crossing
  always_ff @(posedge i_clk_user or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ce_u1 <= 1'b0;
      ce_u2 <= 1'b0;
    end
    else
    begin
      ce_u1 <= i_ce;
      ce_u2 <= ce_u1;
    end
  end

  always_ff @(posedge i_clk_user or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wreq_u1 <= 1'b0;
      wreq_u2 <= 1'b0;
      wreq_u3 <= 1'b0;
      rreq_u1 <= 1'b0;
      rreq_u2 <= 1'b0;
      rreq_u3 <= 1'b0;
    end
    else if (ce_u2)
    begin
      wreq_u1 <= wr_req_tgl;
      wreq_u2 <= wreq_u1;
      wreq_u3 <= wreq_u2;
      rreq_u1 <= rd_req_tgl;
      rreq_u2 <= rreq_u1;
      rreq_u3 <= rreq_u2;
    end
  end

  assign mux_valid = alcrb_pkg::in_fs_area(o_reg_word_address) ? fs_rd_valid
                                                               : i_oe_read_valid; // see RULE2
  assign mux_value = alcrb_pkg::in_fs_area(o_reg_word_address) ? fs_rd_value
                                                               : i_oe_read_value; // see RULE2

  // serialiser: a write wins over a waiting read, never both in one cycle
  always_ff @(posedge i_clk_user or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= alcrb_pkg::ALCRB_IDLE;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wack_tgl <= 1'b0;
      rack_tgl <= 1'b0;
      rd_value_x <= alcrb_pkg::READ_ZERO;
      o_reg_word_address <= 14'h0000;
      o_reg_write_strobe <= 1'b0;
      o_reg_write_value <= 32'h0000_0000;
      o_reg_write_byte_lanes <= 4'h0;
      o_reg_read_request <= 1'b0;
    end
    else if (ce_u2)
    begin
      o_reg_write_strobe <= 1'b0; // see RULE8
      o_reg_read_request <= 1'b0;
      wr_pend <= (wreq_u2 != wreq_u3) || wr_pend;
      rd_pend <= (rreq_u2 != rreq_u3) || rd_pend;
      unique case (state)
        alcrb_pkg::ALCRB_IDLE:
        begin
          if (wr_pend)
          begin
            wr_pend <= (wreq_u2 != wreq_u3);
            o_reg_write_strobe <= 1'b1; // see RULE7 see RULE8
            o_reg_word_address <= wr_payload.addr; // see RULE6
            o_reg_write_value <= wr_payload.value;
            o_reg_write_byte_lanes <= wr_payload.lanes; // see RULE9
            wack_tgl <= !wack_tgl;
          end
          else if (rd_pend)
          begin
            rd_pend <= (rreq_u2 != rreq_u3);
            o_reg_read_request <= 1'b1; // see RULE7 see RULE10
            o_reg_word_address <= rd_word; // see RULE6
            state <= alcrb_pkg::ALCRB_READ;
          end
        end
        alcrb_pkg::ALCRB_READ:
        begin
          // address stays put here until read valid
          if (mux_valid)
          begin
            rd_value_x <= mux_value; // see RULE12
            rack_tgl <= !rack_tgl;
            state <= alcrb_pkg::ALCRB_IDLE; // see RULE11
          end
        end
        default:
        begin
          state <= alcrb_pkg::ALCRB_IDLE;
        end
      endcase
    end
  end

  assign user_wr = '{addr: o_reg_word_address, value: o_reg_write_value,
                     lanes: o_reg_write_byte_lanes};

  alcrb_fs_regs u_fs_regs (
    .i_clk(i_clk_user),
    .i_nrst(i_nrst),
    .i_ce(ce_u2),
    .i_wr_strobe(o_reg_write_strobe),
    .i_wr(user_wr),
    .i_rd_req(o_reg_read_request),
    .i_filesystem_busy(i_filesystem_busy),
    .i_filesystem_error(i_filesystem_error),
    .o_file_name_input(o_file_name_input),
    .o_file_length_input(o_file_length_input),
    .o_file_size_select(o_file_size_select),
    .o_file_timestamp(fs_timestamp),
    .o_filesystem_command_code(o_filesystem_command_code),
    .o_command_start_pulse(o_command_start_pulse),
    .o_rd_value(fs_rd_value),
    .o_rd_valid(fs_rd_valid)
  );

  assign o_timestamp_seconds = fs_timestamp[4:0]; // see RULE20
  assign o_timestamp_minutes = fs_timestamp[10:5];
  assign o_timestamp_hours = fs_timestamp[15:11];
  assign o_timestamp_day = fs_timestamp[20:16];
  assign o_timestamp_month = fs_timestamp[24:21];
  assign o_timestamp_year = fs_timestamp[31:25];

  // checks
  property p_wr_rd_exclusive;
    @(posedge i_clk_user) disable iff (!i_nrst)
    !(o_reg_write_strobe && o_reg_read_request);
  endproperty
  a_wr_rd_exclusive: assert property (p_wr_rd_exclusive) else $error("write and read together"); // see RULE7

  property p_strobe_single;
    @(posedge i_clk_user) disable iff (!i_nrst)
    o_reg_write_strobe |=> !o_reg_write_strobe;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("write strobe too long"); // see RULE8

  property p_addr_held;
    @(posedge i_clk_user) disable iff (!i_nrst)
    (state == alcrb_pkg::ALCRB_READ) && !mux_valid |=> $stable(o_reg_word_address);
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("address moved during read"); // see RULE11

  property p_fs_latency;
    @(posedge i_clk_user) disable iff (!i_nrst)
    o_reg_read_request && ce_u2 && $stable(ce_u2) ##1 ce_u2 |-> ##1 fs_rd_valid;
  endproperty
  a_fs_latency: assert property (p_fs_latency) else $error("filesystem read not two cycles"); // see RULE16

  property p_read_forward;
    @(posedge i_clk_user) disable iff (!i_nrst)
    (state == alcrb_pkg::ALCRB_READ) && mux_valid && ce_u2 |=> rd_value_x == $past(mux_value);
  endproperty
  a_read_forward: assert property (p_read_forward) else $error("read value not forwarded"); // see RULE12

  property p_cmd_pulse;
    @(posedge i_clk_user) disable iff (!i_nrst)
    o_reg_write_strobe && ce_u2 &&
      alcrb_pkg::word_to_byte(o_reg_word_address) == alcrb_pkg::OFF_FILESYSTEM_COMMAND
      |=> o_command_start_pulse;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("no start pulse"); // see RULE21

  property p_no_read_accept_busy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    rd_busy |-> !o_arready;
  endproperty
  a_no_read_accept_busy: assert property (p_no_read_accept_busy) else $error("read accepted twice"); // see RULE25

  property p_bvalid_okay_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    o_bvalid && !i_bready |=> o_bvalid && o_bresp == alcrb_pkg::RESP_OKAY;
  endproperty
  a_bvalid_okay_hold: assert property (p_bvalid_okay_hold) else $error("write response dropped"); // see RULE24

  c_write_done: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) b_done);
  c_read_done: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) r_done);
  c_fs_read: cover property (@(posedge i_clk_user) disable iff (!i_nrst) fs_rd_valid);
  c_start: cover property (@(posedge i_clk_user) disable iff (!i_nrst) o_command_start_pulse);

endmodule
`default_nettype wire

// ### alcrb_oe_model.sv
// Purpose: behavioural offload register file on the user clock
// Assumes: answers every read request, value derived from the held address
// Notes: latency one or three cycles; value bus shows a moving pattern when idle
`timescale 1ns/1ps
`default_nettype none
module alcrb_oe_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_slow,
  input wire logic [13:0] i_addr,
  output logic o_valid,
  output logic [31:0] o_value
);
  logic [2:0] pipe;
  logic [31:0] noise;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pipe <= 3'h0;
      noise <= 32'h0;
    end
    else
    begin
      pipe <= {pipe[1:0], i_req};
      noise <= ~noise + 32'h1357_9BDF;
    end
  end
  assign o_valid = i_slow ? pipe[2] : pipe[0];
  // address read at answer time, so a moved address gives a wrong word
  assign o_value = o_valid ? ({18'h0, i_addr} ^ 32'hC3A5_0000) : noise;
endmodule
`default_nettype wire

// ### test_axi_lite_cdc_register_bridge.sv
// Purpose: self-checking bench of the cpu register bridge
// Assumes: offload model on the far side; clock enable held high
// Notes: random data from an lfsr, partial lane strobes among it
`timescale 1ns/1ps
`default_nettype none
module test_axi_lite_cdc_register_bridge;
  logic i_clk_sys = 0, clk_u = 0, i_nrst = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic busy = 0, err = 0, slow = 0, awr, wr, bv, arr, rv, wstb, rreq, oev, start;
  logic [15:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, wval, oed, ts, lv, ex[5], g, r = 32'h1A9E;
  logic [3:0] ws = 0, wl, ll;
  logic [1:0] br, rr, cmd;
  logic [13:0] ad, la;
  logic [26:0] fn, fl;
  logic [2:0] fs;
  int fails = 0, comparisons = 0, nstb = 0, starts = 0, clash = 0, k, n0, s0;
  always #2 i_clk_sys = ~i_clk_sys;
  initial
  begin
    #1.3;
    forever #3 clk_u = ~clk_u;
  end
  alcrb_bridge alcrb_bridge_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_clk_user(clk_u), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wr), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv), .i_bready(brdy), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rrdy),
    .o_rdata(rd), .o_rresp(rr), .o_reg_word_address(ad), .o_reg_write_strobe(wstb),
    .o_reg_write_value(wval), .o_reg_write_byte_lanes(wl), .o_reg_read_request(rreq),
    .i_oe_read_value(oed), .i_oe_read_valid(oev), .o_file_name_input(fn),
    .o_file_length_input(fl), .o_file_size_select(fs), .o_timestamp_seconds(ts[4:0]),
    .o_timestamp_minutes(ts[10:5]), .o_timestamp_hours(ts[15:11]), .o_timestamp_day(ts[20:16]),
    .o_timestamp_month(ts[24:21]), .o_timestamp_year(ts[31:25]),
    .o_filesystem_command_code(cmd), .o_command_start_pulse(start),
    .i_filesystem_busy(busy), .i_filesystem_error(err));
  alcrb_oe_model alcrb_oe_model_i (.i_clk(clk_u), .i_nrst(i_nrst), .i_req(rreq),
    .i_slow(slow), .i_addr(ad), .o_valid(oev), .o_value(oed));
  always @(posedge clk_u)
  begin
    if (wstb === 1'b1)
    begin
      nstb++;
      la = ad;
      ll = wl;
      lv = wval;
    end
    if (start === 1'b1)
      starts++;
    if (wstb === 1'b1 && rreq === 1'b1)
      clash++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[i*8 +: 8] = d[i*8 +: 8];
    return o;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 300)
    begin
      fails++;
      $display("[ERR] %0t handshake timed out", $time);
      test_done();
    end
  endtask
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(negedge i_clk_sys);
    {awa, wd, ws, awv, wv, brdy} = {a, d, s, 3'b111};
    for (n = 0; n < 300 && brdy; n++)
    begin
      @(posedge i_clk_sys);
      if (awr === 1'b1)
        awv <= 0;
      if (wr === 1'b1)
        wv <= 0;
      if (bv === 1'b1)
      begin
        chk(32'(br), 32'(alcrb_pkg::RESP_OKAY));
        brdy <= 0;
        n = 0;
      end
    end
    hang(n);
  endtask
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    @(negedge i_clk_sys);
    {ara, arv, rrdy} = {a, 2'b11};
    for (n = 0; n < 300 && rrdy; n++)
    begin
      @(posedge i_clk_sys);
      if (arr === 1'b1)
        arv <= 0;
      if (rv === 1'b1)
      begin
        chk(32'(rr), 32'(alcrb_pkg::RESP_OKAY));
        d = rd;
        rrdy <= 0;
        n = 0;
      end
    end
    hang(n);
  endtask
  initial
  begin
    ex = '{default: 32'h0};
    repeat (5) @(negedge i_clk_sys);
    i_nrst = 1;
    repeat (4) @(negedge i_clk_sys);
    for (int i = 0; i < 12; i++)
    begin
      r = lfsr(r);
      k = (i < 5) ? i : r[6:4] % 5;
      {n0, s0} = {nstb, starts};
      ex[k] = mrg(ex[k], r, (i < 5) ? 4'hF : r[3:0]);
      axi_wr(16'(k * 4), r, (i < 5) ? 4'hF : r[3:0]);
      repeat (4) @(negedge i_clk_sys);
      chk(nstb - n0, 1);
      chk({la, ll}, {14'(k), (i < 5) ? 4'hF : r[3:0]});
      chk(lv, r);
      chk(32'(fn), 32'(ex[0][26:0]));
      chk(32'(fl), 32'(ex[1][26:0]));
      chk(32'(fs), 32'(ex[2][2:0]));
      chk(ts, ex[3]);
      chk({cmd, 8'(starts - s0)}, {ex[4][1:0], 8'(k == 4)});
    end
    $display("test parameter writes done");
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      {busy, err, slow} = r[2:0];
      axi_rd(16'h0100, g);
      chk(g, {30'h0, r[1], r[2]});
      axi_rd(16'(r[3:2] * 4), g);
      chk(g, 32'h0);
      axi_rd(16'h0104, g);
      chk(g, 32'h0);
      fork
        axi_wr(16'h0008, r, 4'h1);
        axi_rd({4'h8, r[13:4], 2'h0}, g);
      join
      chk(g, {18'h0, 4'h8, r[13:4]} ^ 32'hC3A5_0000);
      ex[2] = mrg(ex[2], r, 4'h1);
      chk(32'(fs), 32'(ex[2][2:0]));
    end
    chk(clash, 0);
    $display("test reads done");
    test_done();
  end
endmodule
`default_nettype wire
